// *** inc/dma_seq_pkg.sv ***
// shared constants, state layout and register map of the dma channel sequencer
package dma_seq_pkg;
    // =======================================================
    // sizes
    localparam int NCH  = 2;
    localparam int CHW  = 1;
    localparam int IRQW = 7;
    localparam int NDCW = 5;

    // =======================================================
    // global registers, byte offsets
    localparam logic [11:0] G_ON       = 12'h000;
    localparam logic [11:0] G_OFF      = 12'h004;
    localparam logic [11:0] G_FLAGS    = 12'h008;
    localparam logic [11:0] G_IRQ_ON   = 12'h00c;
    localparam logic [11:0] G_IRQ_OFF  = 12'h010;
    localparam logic [11:0] G_IRQ_MASK = 12'h014;

    // =======================================================
    // channel window at (channel+1)*0x40, word index inside it
    localparam logic [3:0] C_IRQ_ON    = 4'h0;
    localparam logic [3:0] C_IRQ_OFF   = 4'h1;
    localparam logic [3:0] C_IRQ_MASK  = 4'h2;
    localparam logic [3:0] C_IRQ_FLAGS = 4'h3;
    localparam logic [3:0] C_SRC       = 4'h4;
    localparam logic [3:0] C_DST       = 4'h5;
    localparam logic [3:0] C_NEXT      = 4'h6;
    localparam logic [3:0] C_DESC      = 4'h7;
    localparam logic [3:0] C_UBLK      = 4'h8;
    localparam logic [3:0] C_BLK       = 4'h9;
    localparam logic [3:0] C_DSTRIDE   = 4'ha;
    localparam logic [3:0] C_SSTRIDE   = 4'hb;
    localparam logic [3:0] C_USTRIDE   = 4'hc;

    // =======================================================
    // field positions
    localparam int IRQ_BLOCK = 0;
    localparam int IRQ_LIST  = 1;
    localparam int IRQ_DIS   = 2;
    localparam int NDC_FETCH = 0;
    localparam int NDC_SUP   = 1;
    localparam int NDC_DUP   = 2;
    localparam int NDC_VIEW  = 3;
    localparam int LW_CTRL   = 24;

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [31:0] WORD_STEP   = 32'h0000_0004;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH, SEQ_MOVE} seq_state_t;

    typedef struct packed {
        logic                      aw_h;
        logic                      w_h;
        logic                      awrdy;
        logic                      wrdy;
        logic                      arrdy;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [1:0]                rresp;
        logic [31:0]               rdata;
        logic [11:0]               awaddr;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic [NCH-1:0]            gact;
        logic [NCH-1:0]            gie;
        logic [NCH-1:0]            dreq;
        logic [NCH-1:0][31:0]      sa;
        logic [NCH-1:0][31:0]      da;
        logic [NCH-1:0][31:0]      next_descriptor_pointer;
        logic [NCH-1:0][31:0]      ds;
        logic [NCH-1:0][23:0]      ubc;
        logic [NCH-1:0][23:0]      sus;
        logic [NCH-1:0][23:0]      dus;
        logic [NCH-1:0][11:0]      block_count;
        logic [NCH-1:0][NDCW-1:0]  ndc;
        logic [NCH-1:0][IRQW-1:0]  ie;
        logic [NCH-1:0][IRQW-1:0]  is;
        seq_state_t                seq;
        logic [CHW-1:0]            ch;
        logic [1:0]                wcnt;
        logic [1:0]                wlast;
        logic                      list;
        logic                      sup;
        logic                      dup;
        logic [23:0]               ucnt;
        logic [11:0]               bcnt;
        logic                      fv;
        logic [31:0]               faddr;
        logic                      fport;
        logic                      mv;
        logic [31:0]               msrc;
        logic [31:0]               mdst;
        logic                      irq;
    } regs_t;

    localparam regs_t REG_RST = '0;
endpackage : dma_seq_pkg

// *** hdl/dma_channel_sequencer.sv ***
// channel setup, descriptor fetch and run control of a small dma engine
`timescale 1ns/1ns

module dma_channel_sequencer
    import dma_seq_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             fetch_valid,
    output logic [31:0]      fetch_addr,
    output logic             fetch_port,
    input  wire logic        fetch_rvalid,
    input  wire logic [31:0] fetch_rdata,
    output logic             move_valid,
    output logic [31:0]      move_src,
    output logic [31:0]      move_dst,
    input  wire logic        move_ready,
    output logic             irq
);

    regs_t       r_q;
    regs_t       r_d;
    logic [31:0] wmask;
    logic [31:0] wbits;

    // =======================================================
    // byte lanes of the held write
    assign wmask = {{8{r_q.wstrb[3]}}, {8{r_q.wstrb[2]}}, {8{r_q.wstrb[1]}}, {8{r_q.wstrb[0]}}};
    assign wbits = r_q.wdata & wmask;

    function automatic logic [31:0] merge(input logic [31:0] old);
        return (old & ~wmask) | wbits;
    endfunction : merge

    // =======================================================
    // outputs straight from the state register
    assign s_axi_awready = r_q.awrdy;
    assign s_axi_wready  = r_q.wrdy;
    assign s_axi_bresp   = r_q.bresp;
    assign s_axi_bvalid  = r_q.bvalid;
    assign s_axi_arready = r_q.arrdy;
    assign s_axi_rdata   = r_q.rdata;
    assign s_axi_rresp   = r_q.rresp;
    assign s_axi_rvalid  = r_q.rvalid;
    assign fetch_valid   = r_q.fv;
    assign fetch_addr    = r_q.faddr;
    assign fetch_port    = r_q.fport;
    assign move_valid    = r_q.mv;
    assign move_src      = r_q.msrc;
    assign move_dst      = r_q.mdst;
    assign irq           = r_q.irq;

    // =======================================================
    // next state: read side, sequencer, write side, in that order
    always_comb begin
        logic           fetch_go, halt, found, wok, rok;
        logic [CHW-1:0] pick, wch, rch, c;
        logic [31:0]    rv;
        fetch_go = 1'b0;
        halt     = 1'b0;
        found    = 1'b0;
        wok      = 1'b0;
        rok      = 1'b0;
        pick     = '0;
        rv       = '0;
        r_d      = r_q;
        wch      = CHW'(r_q.awaddr[11:6] - 6'd1);
        rch      = CHW'(s_axi_araddr[11:6] - 6'd1);
        c        = r_q.ch;

        // address and data are taken in either order and held
        if (s_axi_awvalid && r_q.awrdy) begin
            r_d.aw_h   = 1'b1;
            r_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_q.wrdy) begin
            r_d.w_h   = 1'b1;
            r_d.wdata = s_axi_wdata;
            r_d.wstrb = s_axi_wstrb;
        end
        if (r_q.bvalid && s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end
        if (r_q.rvalid && s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end

        // reads answer one cycle after the address is taken
        if (s_axi_arvalid && r_q.arrdy) begin
            if (s_axi_araddr[11:6] == 6'd0) begin
                rok = 1'b1;
                case (s_axi_araddr)
                    G_FLAGS:    rv = 32'(r_q.gact);
                    G_IRQ_MASK: rv = 32'(r_q.gie);
                    G_ON, G_OFF, G_IRQ_ON, G_IRQ_OFF: rv = '0;
                    default:    rok = 1'b0;
                endcase
            end else if (s_axi_araddr[11:6] <= 6'(NCH)) begin
                rok = 1'b1;
                case (s_axi_araddr[5:2])
                    C_IRQ_MASK:  rv = 32'(r_q.ie[rch]);
                    C_IRQ_FLAGS: begin
                        rv = 32'(r_q.is[rch]);
                        r_d.is[rch] = '0;
                    end
                    C_SRC:       rv = r_q.sa[rch];
                    C_DST:       rv = r_q.da[rch];
                    C_NEXT:      rv = r_q.next_descriptor_pointer[rch];
                    C_DESC:      rv = 32'(r_q.ndc[rch]);
                    C_UBLK:      rv = 32'(r_q.ubc[rch]);
                    C_BLK:       rv = 32'(r_q.block_count[rch]);
                    C_DSTRIDE:   rv = r_q.ds[rch];
                    C_SSTRIDE:   rv = 32'(r_q.sus[rch]);
                    C_USTRIDE:   rv = 32'(r_q.dus[rch]);
                    C_IRQ_ON, C_IRQ_OFF: rv = '0;
                    default:     rok = 1'b0;
                endcase
            end
            r_d.rvalid = 1'b1;
            r_d.rdata  = rv;
            r_d.rresp  = rok ? RESP_OKAY : RESP_SLVERR;
        end

        // sequencer: one engine serves the lowest active channel
        case (r_q.seq)
            SEQ_IDLE: begin
                for (int i = NCH - 1; i >= 0; i--) begin
                    if (r_q.gact[i]) begin
                        found = 1'b1;
                        pick  = CHW'(i);
                    end
                end
                if (found) begin
                    r_d.ch = pick;
                    c      = pick;
                    r_d.ucnt = '0;
                    r_d.bcnt = '0;
                    r_d.list = r_q.ndc[pick][NDC_FETCH];
                    if (r_q.dreq[pick]) begin
                        halt = 1'b1;
                    end else if (r_q.ndc[pick][NDC_FETCH]) begin
                        fetch_go = 1'b1;
                    end else begin
                        r_d.seq = SEQ_MOVE;
                    end
                end
            end
            SEQ_FETCH: begin
                // a running fetch is finished before a stop is honoured
                if (r_q.fv && fetch_rvalid) begin
                    case (r_q.wcnt)
                        2'd0: r_d.next_descriptor_pointer[c] = fetch_rdata;
                        2'd1: begin
                            r_d.ubc[c] = fetch_rdata[23:0];
                            r_d.ndc[c] = fetch_rdata[LW_CTRL +: NDCW];
                        end
                        2'd2:    r_d.sa[c] = r_q.sup ? fetch_rdata : r_q.sa[c];
                        default: r_d.da[c] = r_q.dup ? fetch_rdata : r_q.da[c];
                    endcase
                    if (r_q.wcnt == r_q.wlast) begin
                        r_d.fv   = 1'b0;
                        r_d.seq  = SEQ_MOVE;
                        r_d.ucnt = '0;
                        r_d.bcnt = '0;
                    end else begin
                        r_d.wcnt  = r_q.wcnt + 2'd1;
                        r_d.faddr = r_q.faddr + WORD_STEP;
                    end
                end
            end
            SEQ_MOVE: begin
                if (!r_q.mv) begin
                    if (r_q.dreq[c]) begin
                        halt = 1'b1;
                    end else begin
                        r_d.mv   = 1'b1;
                        r_d.msrc = r_q.sa[c];
                        r_d.mdst = r_q.da[c];
                    end
                end else if (move_ready) begin
                    r_d.mv    = 1'b0;
                    r_d.sa[c] = r_q.sa[c] + WORD_STEP;
                    r_d.da[c] = r_q.da[c] + WORD_STEP;
                    r_d.ucnt  = r_q.ucnt + 24'd1;
                    // a zero length counts as one item or one microblock
                    if (r_q.ucnt + 24'd1 >= r_q.ubc[c]) begin
                        r_d.ucnt  = '0;
                        r_d.sa[c] = r_q.sa[c] + WORD_STEP + {8'h00, r_q.sus[c]};
                        r_d.da[c] = r_q.da[c] + WORD_STEP + {8'h00, r_q.dus[c]};
                        r_d.bcnt  = r_q.bcnt + 12'd1;
                        if (r_q.bcnt + 12'd1 >= r_q.block_count[c]) begin
                            r_d.is[c][IRQ_BLOCK] = 1'b1;
                            if (r_q.ndc[c][NDC_FETCH]) begin
                                fetch_go = 1'b1;
                            end else begin
                                r_d.gact[c] = 1'b0;
                                r_d.dreq[c] = 1'b0;
                                r_d.seq     = SEQ_IDLE;
                                if (r_q.list) begin
                                    r_d.is[c][IRQ_LIST] = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
            default: r_d.seq = SEQ_IDLE;
        endcase

        // stop between items; flag set wins over a read clear
        if (halt) begin
            r_d.gact[c]        = 1'b0;
            r_d.dreq[c]        = 1'b0;
            r_d.is[c][IRQ_DIS] = 1'b1;
            r_d.seq            = SEQ_IDLE;
        end

        // word count of a fetch follows the layout now in force
        if (fetch_go) begin
            r_d.seq   = SEQ_FETCH;
            r_d.wcnt  = '0;
            r_d.wlast = (r_d.ndc[c][NDC_VIEW +: 2] == 2'd0) ? 2'd1 :
                        (r_d.ndc[c][NDC_VIEW +: 2] == 2'd1) ? 2'd2 : 2'd3;
            r_d.sup   = r_d.ndc[c][NDC_SUP];
            r_d.dup   = r_d.ndc[c][NDC_DUP];
            r_d.fv    = 1'b1;
            r_d.faddr = {r_d.next_descriptor_pointer[c][31:2], 2'b00};
            r_d.fport = r_d.next_descriptor_pointer[c][0];
        end

        // writes land after the sequencer so a software enable wins
        if (r_q.aw_h && r_q.w_h && !r_q.bvalid) begin
            r_d.aw_h   = 1'b0;
            r_d.w_h    = 1'b0;
            r_d.bvalid = 1'b1;
            wok        = 1'b1;
            if (r_q.awaddr[11:6] == 6'd0) begin
                case (r_q.awaddr)
                    G_ON:      r_d.gact = r_d.gact | wbits[NCH-1:0];
                    G_OFF:     r_d.dreq = r_d.dreq | (wbits[NCH-1:0] & r_d.gact);
                    G_IRQ_ON:  r_d.gie = r_q.gie | wbits[NCH-1:0];
                    G_IRQ_OFF: r_d.gie = r_q.gie & ~wbits[NCH-1:0];
                    G_FLAGS, G_IRQ_MASK: wok = 1'b1;
                    default:   wok = 1'b0;
                endcase
            end else if (r_q.awaddr[11:6] <= 6'(NCH)) begin
                case (r_q.awaddr[5:2])
                    C_IRQ_ON:  r_d.ie[wch] = r_q.ie[wch] | wbits[IRQW-1:0];
                    C_IRQ_OFF: r_d.ie[wch] = r_q.ie[wch] & ~wbits[IRQW-1:0];
                    C_SRC:     r_d.sa[wch] = merge(r_q.sa[wch]);
                    C_DST:     r_d.da[wch] = merge(r_q.da[wch]);
                    C_NEXT:    r_d.next_descriptor_pointer[wch] = merge(r_q.next_descriptor_pointer[wch]);
                    C_DSTRIDE: r_d.ds[wch] = merge(r_q.ds[wch]);
                    C_DESC:    r_d.ndc[wch] = NDCW'(merge(32'(r_q.ndc[wch])));
                    C_UBLK:    r_d.ubc[wch] = 24'(merge({8'h00, r_q.ubc[wch]}));
                    C_BLK:     r_d.block_count[wch] = 12'(merge({20'h00000, r_q.block_count[wch]}));
                    C_SSTRIDE: r_d.sus[wch] = 24'(merge({8'h00, r_q.sus[wch]}));
                    C_USTRIDE: r_d.dus[wch] = 24'(merge({8'h00, r_q.dus[wch]}));
                    C_IRQ_MASK, C_IRQ_FLAGS: wok = 1'b1;
                    default:   wok = 1'b0;
                endcase
            end else begin
                wok = 1'b0;
            end
            r_d.bresp = wok ? RESP_OKAY : RESP_SLVERR;
        end

        // one hold per channel, so ready drops while something is held
        r_d.awrdy = !r_d.aw_h;
        r_d.wrdy  = !r_d.w_h;
        r_d.arrdy = !r_d.rvalid;

        // interrupt line needs both the channel and the global enable
        r_d.irq = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (r_d.gie[i] && |(r_d.is[i] & r_d.ie[i])) begin
                r_d.irq = 1'b1;
            end
        end
    end

    // =======================================================
    // state register; clock enable freezes everything, but a low aresetn still loads the reset value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q <= REG_RST;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

endmodule : dma_channel_sequencer

// *** sim/dma_mem_model.sv ***
// memory and peripheral side model for descriptor fetch and item moves
`timescale 1ns/1ns
module dma_mem_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        slow,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_rvalid,
    output logic [31:0]      fetch_rdata,
    input  wire logic        move_valid,
    output logic             move_ready
);
    logic [31:0] mem [0:63];
    logic [1:0]  wait_q;

    // =======================================
    // one word every other cycle; idle data inverts so stale words never match
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_rvalid <= 1'b0;
            fetch_rdata  <= 32'h0000_0000;
            wait_q       <= 2'd0;
            move_ready   <= 1'b0;
        end else begin
            fetch_rvalid <= fetch_valid && !fetch_rvalid;
            fetch_rdata  <= fetch_valid ? mem[fetch_addr[7:2]] : ~fetch_rdata;
            wait_q       <= move_valid ? wait_q + 2'd1 : 2'd0;
            move_ready   <= move_valid && !move_ready && (!slow || wait_q == 2'd3);
        end
    end
endmodule : dma_mem_model

// *** sim/dma_seq_monitor.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
module dma_seq_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic        fetch_rvalid,
    input wire logic        move_valid,
    input wire logic        move_ready,
    input wire logic [31:0] move_src,
    input wire logic [31:0] move_dst
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // =======================================
    // handshake steps
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence word_taken;
        fetch_valid && fetch_rvalid;
    endsequence
    sequence item_taken;
        move_valid && move_ready;
    endsequence

    // =======================================
    // register bus and port checks
    a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer not two cycles later");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_fetch_holds: assert property (fetch_valid && !fetch_rvalid |=> fetch_valid && $stable(fetch_addr))
        else $error("fetch request dropped");
    a_fetch_aligned: assert property (fetch_valid |-> fetch_addr[1:0] == 2'b00)
        else $error("fetch address unaligned");
    a_fetch_step: assert property (word_taken ##1 fetch_valid |-> fetch_addr == $past(fetch_addr) + 32'h4)
        else $error("fetch word step wrong");
    a_move_holds: assert property (move_valid && !move_ready |=> move_valid && $stable(move_src) && $stable(move_dst))
        else $error("move request dropped");
    a_move_gap: assert property (item_taken |=> !move_valid)
        else $error("move valid not lowered");
endmodule : dma_seq_monitor

// *** sim/dma_channel_sequencer_bench.sv ***
// self-checking bench for the dma channel sequencer
`timescale 1ns/1ns
module dma_channel_sequencer_bench;
    import dma_seq_pkg::*;
    logic        aclk, aresetn, ce, slow, irq, late;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, fetch_addr, fetch_rdata, move_src, move_dst, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        fetch_valid, fetch_port, fetch_rvalid, move_valid, move_ready;
    logic [63:0] mq [$];
    logic [31:0] fq [$];
    int          fails, check_count, cycles;

    dma_channel_sequencer u_dma_channel_sequencer (.*);
    dma_mem_model u_dma_mem_model (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // =======================================
    // logs of accepted items and fetched words, plus hang limit
    always @(posedge aclk) begin
        if (move_valid && move_ready) mq.push_back({move_src, move_dst});
        if (fetch_valid && fetch_rvalid) fq.push_back(fetch_addr | {31'h0, fetch_port});
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    // =======================================
    // bus tasks and compare
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        fork
            begin
                do @(posedge aclk); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= {1'b1, !late};
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        // a late rready makes the design hold its read answer
        if (late) begin
            repeat (2) @(posedge aclk);
            s_axi_rready <= 1'b1;
        end
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr

    function automatic logic [11:0] ca(input logic [3:0] i);
        return {6'h01, i, 2'b00};
    endfunction : ca

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // polls channel 0 until idle; bounded so a stuck channel shows as a mismatch
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            axr(G_FLAGS);
            n++;
        end while (rd[0] !== 1'b0 && n < 200);
        chk(rd, 32'h0);
    endtask : wait_idle

    task automatic close_out();
        if (fails == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out

    // =======================================
    // scenarios
    task automatic t_bus();
        axr(12'hffc);
        chk(rsp, RESP_SLVERR);
        chk(rd, 32'h0);
        axw(12'hffc, 32'hffff_ffff);
        chk(rsp, RESP_SLVERR);
        axw(G_FLAGS, 32'h3);
        late = 1'b1;
        axr(G_FLAGS);
        late = 1'b0;
        chk(rd, 32'h0);
    endtask : t_bus

    task automatic t_single();
        int i;
        slow <= 1'b1;
        axw(ca(C_DESC), 32'h0);
        axw(ca(C_DSTRIDE), 32'h0);
        axw(ca(C_SSTRIDE), 32'h0);
        axw(ca(C_USTRIDE), 32'h0);
        axw(ca(C_SRC), 32'h0000_1000);
        axw(ca(C_DST), 32'h0000_2000);
        axw(ca(C_UBLK), 32'h2);
        axw(ca(C_BLK), 32'h2);
        axw(ca(C_IRQ_ON), 32'h1);
        axw(G_IRQ_ON, 32'h1);
        axw(G_ON, 32'h1);
        axw(G_OFF, 32'h0);
        axr(G_FLAGS);
        chk(rd, 32'h1);
        i = 0;
        while (irq !== 1'b1 && i < 500) begin
            @(posedge aclk);
            i++;
        end
        chk({31'h0, irq}, 32'h1);
        wait_idle();
        chk(mq.size(), 32'h4);
        for (i = 0; i < 4; i++) begin
            chk(mq[i][63:32], 32'h0000_1000 + 32'(4 * i));
            chk(mq[i][31:0], 32'h0000_2000 + 32'(4 * i));
        end
        axr(ca(C_IRQ_FLAGS));
        chk(rd, 32'h1);
        axr(ca(C_IRQ_FLAGS));
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        mq.delete();
    endtask : t_single

    task automatic t_list();
        slow <= 1'b0;
        u_dma_mem_model.mem[16] = 32'h0000_0050;
        u_dma_mem_model.mem[17] = 32'h1500_0001;
        u_dma_mem_model.mem[18] = 32'h0000_3000;
        u_dma_mem_model.mem[20] = 32'h0000_0000;
        u_dma_mem_model.mem[21] = 32'h0000_0002;
        u_dma_mem_model.mem[22] = 32'h0000_4000;
        u_dma_mem_model.mem[23] = 32'h0000_5000;
        axw(ca(C_BLK), 32'h1);
        axw(ca(C_NEXT), 32'h0000_0041);
        axw(ca(C_DESC), 32'h0000_000b);
        axw(ca(C_IRQ_ON), 32'h7e);
        axr(ca(C_IRQ_MASK));
        chk(rd, 32'h7f);
        axw(ca(C_IRQ_OFF), 32'h7c);
        axr(ca(C_IRQ_MASK));
        chk(rd, 32'h3);
        axr(G_FLAGS);
        chk(rd, 32'h0);
        axw(G_ON, 32'h1);
        wait_idle();
        chk(fq.size(), 32'h7);
        chk(fq[0], 32'h0000_0041);
        chk(fq[6] & 32'hffff_fffc, 32'h0000_005c);
        chk(mq.size(), 32'h3);
        chk(mq[0][63:32], 32'h0000_3000);
        chk({31'h0, mq[1][63:32] != 32'h0000_4000}, 32'h1);
        chk(mq[1][31:0], 32'h0000_5000);
        axr(ca(C_IRQ_FLAGS));
        chk(rd, 32'h3);
        mq.delete();
    endtask : t_list

    task automatic t_stop();
        slow <= 1'b1;
        axw(ca(C_DESC), 32'h0);
        axw(ca(C_UBLK), 32'd100);
        axw(G_ON, 32'h1);
        axw(G_OFF, 32'h1);
        wait_idle();
        chk({31'h0, mq.size() < 100}, 32'h1);
        axr(ca(C_IRQ_FLAGS));
        chk(rd, 32'h4);
    endtask : t_stop

    // =======================================
    // reset for 20 cycles, then the scenarios
    initial begin
        {aresetn, slow, late, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        ce = 1'b1;
        {fails, check_count, cycles} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_bus();
        t_single();
        t_list();
        t_stop();
        close_out();
    end
endmodule : dma_channel_sequencer_bench

bind dma_channel_sequencer dma_seq_monitor u_dma_seq_monitor (.*);
